/* File: sim/chain_host_model.sv */
// host model: pulses the chain's convert line and times every phase
// assumes chain_out is settled at each falling edge of clk
`default_nettype none
`include "pwm_chain_cfg.svh"
module chain_host_model (
    input  wire logic                          clk,
    input  wire logic                          go,
    input  wire logic                          chain_out,
    output logic                               convert_start_input,
    output logic                               done,
    output logic [`CHAIN_LEN-1:0][`LOW_W-1:0] hi_len,
    output logic [`CHAIN_LEN-1:0][`LOW_W-1:0] lo_len
);
    timeunit 1ns;
    timeprecision 1ps;
    real temp_c;
    // count one phase, leaving at its first opposite sample
    task automatic measure(input logic lvl, output logic [`LOW_W-1:0] n);
        n = '0;
        while (chain_out === lvl && n < 24'h0003E8) begin
            n = n + 24'h000001;
            @(negedge clk);
        end
    endtask
    // one pulse per request, then a high/low pair per sensor in order
    initial begin
        convert_start_input = 1'b0;
        done = 1'b1;
        forever begin
            @(posedge go);
            done = 1'b0;
            @(negedge clk) convert_start_input = 1'b1;
            // sensor 0 high starts at the edge that takes the pulse
            @(negedge clk) convert_start_input = 1'b0;
            for (int i = 0; i < `CHAIN_LEN; i++) begin
                measure(1'b1, hi_len[i]);
                measure(1'b0, lo_len[i]);
                temp_c = 421.0 - 751.0 * hi_len[i] / lo_len[i];
            end
            done = 1'b1;
        end
    end
endmodule // chain_host_model
`default_nettype wire

/* File: sim/pwm_temp_chain_reader_test.sv */
// self-checking bench for the pwm sensor chain
// assumes chain_host_model and a 250 MHz clock
`default_nettype none
`include "pwm_chain_cfg.svh"
module pwm_temp_chain_reader_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned HIGH = 4;
    logic                               clk, rst_n, go, cont, conv;
    logic [`LOW_W-1:0]                 low_phase_length;
    logic                               sample_valid, sample_ready;
    logic                               chain_out, busy, done;
    logic [`CHAIN_LEN-1:0][`LOW_W-1:0] hi_len, lo_len;
    int                                 miscompares = 0;
    int                                 samples_checked = 0;
    int                                 cycles = 0;
    pwm_temp_chain_reader #(.HIGH_PHASE_CYCLES(HIGH)) u_dut (
        .clk(clk), .rst_n(rst_n), .convert_start_input(conv),
        .continuous_mode(cont), .low_phase_length(low_phase_length),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .chain_out(chain_out), .busy(busy));
    chain_host_model u_host (.clk(clk), .go(go), .chain_out(chain_out),
        .convert_start_input(conv), .done(done), .hi_len(hi_len),
        .lo_len(lo_len));
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic check(input logic [`LOW_W-1:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %0h vs %0h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, exp);
        check({23'h000000, got}, {23'h000000, exp});
    endtask
    task automatic wait_busy(input logic lvl);
        for (int n = 0; n < 100 && busy !== lvl; n++) @(negedge clk);
        check_bit(busy, lvl);
    endtask
    // two words back to back, valid held until each is taken;
    // ready is a flop, so its level before the edge decides the take
    task automatic send2(input logic [`LOW_W-1:0] a, b);
        for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            low_phase_length = k ? b : a;
            sample_valid = 1'b1;
            while (sample_ready !== 1'b1) @(negedge clk);
            @(posedge clk);
        end
        @(negedge clk) sample_valid = 1'b0;
    endtask
    task automatic start();
        @(negedge clk) go = 1'b1;
        @(negedge clk) go = 1'b0;
    endtask
    // wait for the host model, then judge the timed pairs
    task automatic finish_frame(input logic [`LOW_W-1:0] l0, l1);
        for (int n = 0; n < 200 && done !== 1'b1; n++) @(negedge clk);
        check_bit(done, 1'b1);
        check(hi_len[0], 24'(HIGH));
        check(hi_len[1], 24'(HIGH));
        check(lo_len[0], l0);
        check(lo_len[1], l1);
        check_bit(busy, 1'b0);
        check_bit(chain_out, 1'b1);
    endtask
    task automatic test_reset();
        check_bit(sample_ready, 1'b1);
        check_bit(chain_out, 1'b1);
        check_bit(busy, 1'b0);
        $display("test reset done");
    endtask
    // zero low length acts as one
    task automatic test_oneshot();
        send2(24'h000005, 24'h000000);
        repeat (3) @(negedge clk);
        start();
        finish_frame(24'h000005, 24'h000001);
        $display("test oneshot done");
    endtask
    // words sent mid-frame wait in the buffer and apply next frame
    task automatic test_stall();
        start();
        wait_busy(1'b1);
        send2(24'h000007, 24'h000003);
        @(negedge clk);
        check_bit(sample_ready, 1'b0);
        finish_frame(24'h000005, 24'h000001);
        repeat (3) @(negedge clk);
        check_bit(sample_ready, 1'b1);
        start();
        finish_frame(24'h000007, 24'h000003);
        $display("test stall done");
    endtask
    // free-running frames with one idle clock between them
    task automatic test_continuous();
        @(negedge clk) cont = 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        check_bit(chain_out, 1'b1);
        @(negedge clk);
        check_bit(busy, 1'b1);
        cont = 1'b0;
        wait_busy(1'b0);
        repeat (3) @(negedge clk);
        check_bit(busy, 1'b0);
        $display("test continuous done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // reset, then each scenario in turn
    initial begin
        rst_n = 1'b0;
        go = 1'b0;
        cont = 1'b0;
        low_phase_length = '0;
        sample_valid = 1'b0;
        repeat (8) @(negedge clk);
        test_reset();
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        test_reset();
        test_oneshot();
        test_stall();
        test_continuous();
        finish_test();
    end
endmodule // pwm_temp_chain_reader_test
`default_nettype wire

/* File: verilog/pwm_chain_cfg.svh */
// constants for the pwm temperature chain
// assumes a 250 MHz system clock; included by bare name
`ifndef PWM_CHAIN_CFG_SVH
`define PWM_CHAIN_CFG_SVH

`define CLK_PERIOD_NS  4
`define HIGH_TIME_NS   40000
`define CHAIN_LEN      2
`define CHAIN_MAX      4
`define LOW_W          24
`define STAGE_W        2
`define BUF_DEPTH      2
`define LOW_RESET      24'h000001
`define RST_SYNC_INIT  2'h0

`endif

/* File: verilog/pwm_chain_pkg.sv */
// types shared by the pwm temperature chain files
// assumes pwm_chain_cfg.svh is on the include path
`default_nettype none

package pwm_chain_pkg;

    // one-hot phase of the chain waveform
    typedef enum logic [2:0] {
        PH_IDLE = 3'h1,
        PH_HIGH = 3'h2,
        PH_LOW  = 3'h4
    } phase_type;

endpackage

`default_nettype wire

/* File: verilog/pwm_temp_chain_reader.sv */
// pwm temperature sensor chain: combined output waveform of the chain
// assumes one 250 MHz clock; low lengths arrive over a valid/ready stream
//
// Overview of operation
// - each sensor gives a fixed-length high phase and a temperature-set low phase.
// - each sensor's finished output starts conversion of the next sensor.
// - the returned line carries every sensor's high/low pair in chain order.
// - one-shot or continuous operation; the reader must match the mode used.
`default_nettype none
`include "pwm_chain_cfg.svh"

module pwm_temp_chain_reader #(
    parameter int unsigned HIGH_PHASE_CYCLES = `HIGH_TIME_NS / `CLK_PERIOD_NS
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              convert_start_input,
    input  wire logic              continuous_mode,
    input  wire logic [`LOW_W-1:0] low_phase_length,
    input  wire logic              sample_valid,
    output logic                   sample_ready,
    output logic                   chain_out,
    output logic                   busy
);

    localparam logic [`LOW_W-1:0] HIGH_LEN = HIGH_PHASE_CYCLES[`LOW_W-1:0];
    localparam logic [`STAGE_W-1:0] LAST_STAGE =
        2'(`CHAIN_LEN - 1);

    // low length in cycles, zero treated as one
    function automatic logic [`LOW_W-1:0] low_cycles(
        input logic [`LOW_W-1:0] v);
        low_cycles = (v == '0) ? `LOW_W'(1) : v;
    endfunction

    // true for the final sensor of the chain
    function automatic logic is_last(input logic [`STAGE_W-1:0] s);
        is_last = (s == LAST_STAGE);
    endfunction

    // reset release through two flops
    logic [1:0] rst_sync_q;
    wire        srst_n = rst_sync_q[1];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= `RST_SYNC_INIT;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    pwm_chain_pkg::phase_type phase_q;
    pwm_chain_pkg::phase_type phase_d;
    logic [`LOW_W-1:0]        cnt_q;
    logic [`LOW_W-1:0]        cnt_d;
    logic [`STAGE_W-1:0]      stage_q;
    logic [`STAGE_W-1:0]      stage_d;
    logic [`STAGE_W-1:0]      load_idx_q;
    logic [`LOW_W-1:0]        low_len_q [`CHAIN_MAX];
    logic                     chain_out_q;
    logic                     busy_q;
    logic [`LOW_W-1:0]        buf_data;
    logic                     buf_valid;

    // buffered stream of low lengths, drained only between frames
    wire drain_ready = (phase_q == pwm_chain_pkg::PH_IDLE);
    wire load        = buf_valid && drain_ready;

    two_entry_buffer u_buf (
        .clk       (clk),
        .rst_n     (srst_n),
        .in_data   (low_phase_length),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (drain_ready)
    );

    // phase decode
    wire in_idle  = (phase_q == pwm_chain_pkg::PH_IDLE);
    wire in_high  = (phase_q == pwm_chain_pkg::PH_HIGH);
    wire in_low   = (phase_q == pwm_chain_pkg::PH_LOW);
    wire cnt_done = (cnt_q == '0);
    wire start    = in_idle && (convert_start_input || continuous_mode);
    wire high_end = in_high && cnt_done;
    wire low_end  = in_low && cnt_done;
    wire handoff  = low_end && !is_last(stage_q);
    wire frame_end = low_end && is_last(stage_q);
    wire [`LOW_W-1:0] next_low = low_cycles(low_len_q[stage_q]) - `LOW_W'(1);

    // next phase, stage and counter
    assign phase_d = (start || handoff) ? pwm_chain_pkg::PH_HIGH :
                     high_end  ? pwm_chain_pkg::PH_LOW :
                     frame_end ? pwm_chain_pkg::PH_IDLE : phase_q;
    assign stage_d = start   ? '0 :
                     handoff ? stage_q + `STAGE_W'(1) : stage_q;
    assign cnt_d   = (start || handoff) ? HIGH_LEN - `LOW_W'(1) :
                     high_end ? next_low :
                     cnt_done ? cnt_q : cnt_q - `LOW_W'(1);

    // waveform sequencer; line idles high, low only in low phases
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            phase_q     <= pwm_chain_pkg::PH_IDLE;
            stage_q     <= '0;
            cnt_q       <= '0;
            chain_out_q <= 1'b1;
            busy_q      <= 1'b0;
        end else begin
            phase_q     <= phase_d;
            stage_q     <= stage_d;
            cnt_q       <= cnt_d;
            chain_out_q <= (phase_d != pwm_chain_pkg::PH_LOW);
            busy_q      <= (phase_d != pwm_chain_pkg::PH_IDLE);
        end
    end

    // per-sensor low lengths loaded in chain order
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            load_idx_q <= '0;
            for (int i = 0; i < `CHAIN_MAX; i++) begin
                low_len_q[i] <= `LOW_RESET;
            end
        end else if (load) begin
            low_len_q[load_idx_q] <= buf_data;
            load_idx_q <= is_last(load_idx_q) ? '0
                                              : load_idx_q + `STAGE_W'(1);
        end
    end

    assign chain_out = chain_out_q;
    assign busy      = busy_q;

    // helper: length of the current phase so far
    logic [`LOW_W-1:0] run_q;
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            run_q <= '0;
        end else begin
            run_q <= (phase_d != phase_q || start || handoff) ? `LOW_W'(1)
                                                              : run_q + `LOW_W'(1);
        end
    end

    sequence low_done_s;
        in_low && cnt_done && !is_last(stage_q);
    endsequence

    sequence next_high_s;
        in_high && chain_out_q && busy_q;
    endsequence

    sequence low_entry_s;
        in_low && !chain_out_q && busy_q;
    endsequence

    high_phase_len_a: assert property (@(posedge clk) disable iff (!srst_n)
        high_end |-> run_q == HIGH_LEN)
        else $error("high phase length differs from fixed length");

    low_phase_len_a: assert property (@(posedge clk) disable iff (!srst_n)
        low_end |-> run_q == low_cycles(low_len_q[stage_q]))
        else $error("low phase length differs from sensor value");

    chain_handoff_a: assert property (@(posedge clk) disable iff (!srst_n)
        low_done_s |=> next_high_s
                       ##0 stage_q == $past(stage_q) + `STAGE_W'(1))
        else $error("next sensor not started by predecessor");

    frame_end_a: assert property (@(posedge clk) disable iff (!srst_n)
        frame_end |=> in_idle && chain_out_q && !busy_q)
        else $error("line did not return high after last sensor");

    line_level_a: assert property (@(posedge clk) disable iff (!srst_n)
        (in_low |-> !chain_out_q) and (!in_low |-> chain_out_q))
        else $error("line level disagrees with phase");

    one_shot_hold_a: assert property (@(posedge clk) disable iff (!srst_n)
        (in_idle && !continuous_mode && !convert_start_input) |=> in_idle)
        else $error("one-shot chain started without convert");

    cont_restart_a: assert property (@(posedge clk) disable iff (!srst_n)
        (in_idle && continuous_mode) |=> in_high && stage_q == '0 && busy_q)
        else $error("continuous mode did not restart the chain");

    convert_start_a: assert property (@(posedge clk) disable iff (!srst_n)
        (in_idle && convert_start_input) |=> busy_q && in_high)
        else $error("convert pulse did not start a measurement");

    // helper: sensors handed on so far in the current frame
    logic [`STAGE_W-1:0] pairs_q;
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            pairs_q <= '0;
        end else if (start) begin
            pairs_q <= '0;
        end else if (handoff) begin
            pairs_q <= pairs_q + `STAGE_W'(1);
        end
    end

    low_entry_a: assert property (@(posedge clk) disable iff (!srst_n)
        high_end |=> low_entry_s ##0 cnt_q == $past(next_low))
        else $error("low phase did not follow the high phase");

    high_count_a: assert property (@(posedge clk) disable iff (!srst_n)
        (in_high && !cnt_done) |=> in_high && cnt_q == $past(cnt_q) - `LOW_W'(1))
        else $error("high phase counter skipped or stopped");

    stage_range_a: assert property (@(posedge clk) disable iff (!srst_n)
        busy_q |-> stage_q <= LAST_STAGE)
        else $error("stage index beyond the chain");

    drain_idle_a: assert property (@(posedge clk) disable iff (!srst_n)
        load |-> in_idle && !busy_q)
        else $error("sensor slot loaded during a frame");

    frame_pairs_a: assert property (@(posedge clk) disable iff (!srst_n)
        frame_end |-> pairs_q == LAST_STAGE)
        else $error("frame ended with a sensor missing");

endmodule // pwm_temp_chain_reader

`default_nettype wire

/* File: verilog/two_entry_buffer.sv */
// two-entry buffer with valid/ready on both sides
// assumes a synchronous-release active-low reset from the top
`default_nettype none
`include "pwm_chain_cfg.svh"

module two_entry_buffer (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [`LOW_W-1:0] in_data,
    input  wire logic              in_valid,
    output logic                   in_ready,
    output logic [`LOW_W-1:0]      out_data,
    output logic                   out_valid,
    input  wire logic              out_ready
);

    logic [`LOW_W-1:0] mem_q [`BUF_DEPTH];
    logic [1:0]        count_q;
    logic [1:0]        count_d;
    logic              wr_ptr_q;
    logic              rd_ptr_q;
    logic              ready_q;
    wire               push = in_valid && ready_q;
    wire               pop  = out_valid && out_ready;

    // occupancy bookkeeping
    assign count_d   = count_q + {1'b0, push} - {1'b0, pop};
    assign out_valid = (count_q != 2'h0);
    assign out_data  = mem_q[rd_ptr_q];
    assign in_ready  = ready_q;

    // pointers and full flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q  <= 2'h0;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            ready_q  <= 1'b1;
        end else begin
            count_q  <= count_d;
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            ready_q  <= (count_d != 2'h2); // full stalls the source
        end
    end

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    buf_no_overflow_a: assert property (@(posedge clk) disable iff (!rst_n)
        (count_q == 2'h2) |-> !in_ready)
        else $error("buffer accepts data while full");

endmodule // two_entry_buffer

`default_nettype wire
